// [rtl/strap_clock_pkg.sv]
// strap decode types, reset values and selector constants
// assumes every three-level strap reaches the core as two sensed levels,
// one taken with a weak pull-up and one with a weak pull-down
package strap_clock_pkg;

    // ------------------------------------------------------------
    // three-level strap states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        STRAP_LOW  = 2'h0,
        STRAP_HIGH = 2'h1,
        STRAP_OPEN = 2'h2
    } strap_level_t;

    // ------------------------------------------------------------
    // decoded settings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IO_LVDS   = 2'h0,
        IO_HCSL   = 2'h1,
        IO_LVCMOS = 2'h2
    } io_type_t;

    typedef enum logic [1:0] {
        EDGE_SLOW   = 2'h0,
        EDGE_MEDIUM = 2'h1,
        EDGE_FAST   = 2'h2
    } edge_rate_t;

    // prescaler ratio code: ratio is 2**code
    typedef enum logic [1:0] {
        DIV_1 = 2'h0,
        DIV_2 = 2'h1,
        DIV_4 = 2'h2,
        DIV_8 = 2'h3
    } prescale_t;

    typedef enum logic [1:0] {
        SEL_MANUAL_PRI = 2'h0,
        SEL_MANUAL_SEC = 2'h1,
        SEL_AUTO       = 2'h2
    } sel_mode_t;

    // gray order along pri -> to_sec -> sec -> to_pri -> pri
    typedef enum logic [1:0] {
        MUX_PRI    = 2'h0,
        MUX_TO_SEC = 2'h1,
        MUX_SEC    = 2'h3,
        MUX_TO_PRI = 2'h2
    } mux_state_t;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam io_type_t RST_OUTPUT_TYPE = IO_LVCMOS;
    localparam edge_rate_t RST_EDGE_RATE = EDGE_FAST;
    localparam io_type_t RST_INPUT_TYPE = IO_LVCMOS;
    localparam prescale_t RST_PRESCALE = DIV_1;
    localparam logic RST_MUX_OUT = 1'b0;
    localparam int RESTORE_CYCLES = 4;
    localparam int LOS_TIMEOUT_EDGES = 8;
    localparam int PRESCALE_CNT_W = 2;

    // ------------------------------------------------------------
    // three-level sense: pulled-up level, pulled-down level
    // ------------------------------------------------------------
    function automatic strap_level_t decode_strap(input logic sense_up,
                                                  input logic sense_dn);
        strap_level_t lvl;
        lvl = STRAP_OPEN;
        if (sense_up && sense_dn) begin
            lvl = STRAP_HIGH;
        end else if (!sense_up && !sense_dn) begin
            lvl = STRAP_LOW;
        end
        return lvl;
    endfunction

endpackage

// [rtl/clock_loss_monitor.sv]
// loss-of-signal detector for one oversampled clock input
// assumes edge pulses come from synchronised levels in the clk domain
`timescale 1ns/1ps
module clock_loss_monitor import strap_clock_pkg::*; #(
    parameter int TIMEOUT_EDGES = LOS_TIMEOUT_EDGES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // edge pulses
    input wire logic mon_rise,
    input wire logic ref_rise,
    // status
    output logic lost
);

    if (TIMEOUT_EDGES < 2 || TIMEOUT_EDGES > 255) begin
        $error("clock_loss_monitor: TIMEOUT_EDGES out of range");
    end

    localparam logic [7:0] TIMEOUT_LIM = 8'(TIMEOUT_EDGES);

    logic [7:0] gap_cnt_r;
    logic lost_r;

    // --------------------------------------------------------
    // count edges of the other clock since our last edge
    // --------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_cnt_r <= 8'h00;
        end else if (mon_rise) begin
            gap_cnt_r <= 8'h00;
        end else if (ref_rise && gap_cnt_r != TIMEOUT_LIM) begin
            gap_cnt_r <= gap_cnt_r + 8'h01;
        end
    end

    // lost once the window closes, cleared by our next edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lost_r <= 1'b0;
        end else if (mon_rise) begin
            lost_r <= 1'b0;
        end else if (gap_cnt_r == TIMEOUT_LIM) begin
            lost_r <= 1'b1;
        end
    end

    assign lost = lost_r;

endmodule

// [rtl/strap_clock_select.sv]
// strap decoder and smart input clock selector of the fan-out buffer
// assumes both reference clocks are far slower than clk and are
// oversampled; straps are sensed once with pull-up, once with pull-down
`timescale 1ns/1ps
module strap_clock_select import strap_clock_pkg::*; #(
    parameter int TIMEOUT_EDGES = LOS_TIMEOUT_EDGES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // three-level straps, sensed with pull-up and pull-down
    input wire logic output_type_strap_up,
    input wire logic output_type_strap_dn,
    input wire logic edge_rate_strap_up,
    input wire logic edge_rate_strap_dn,
    input wire logic input_type_strap_up,
    input wire logic input_type_strap_dn,
    input wire logic prescale_strap_up,
    input wire logic prescale_strap_dn,
    input wire logic input_select_pin_up,
    input wire logic input_select_pin_dn,
    // global output enable pin
    input wire logic output_enable_pin,
    // host configuration path
    input wire logic host_mode,
    input wire logic [1:0] host_prescale,
    // reference clocks
    input wire logic primary_clock_input,
    input wire logic secondary_clock_input,
    // decoded configuration
    output io_type_t output_type,
    output edge_rate_t edge_rate,
    output io_type_t input_type,
    output prescale_t secondary_prescaler,
    output logic outputs_enabled,
    output logic outputs_hiz,
    output logic primary_buf_on,
    output logic secondary_buf_on,
    // selector
    output logic mux_clk,
    output logic on_secondary,
    output logic primary_lost,
    output logic secondary_lost
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 14;
    logic [NSYNC-1:0] pins_in;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;

    assign pins_in = {output_type_strap_up, output_type_strap_dn,
                      edge_rate_strap_up, edge_rate_strap_dn,
                      input_type_strap_up, input_type_strap_dn,
                      prescale_strap_up, prescale_strap_dn,
                      input_select_pin_up, input_select_pin_dn,
                      output_enable_pin, host_mode,
                      primary_clock_input, secondary_clock_input};

    // two flops on every pin except host_prescale before any logic looks at it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pins_in;
            sync2_r <= sync1_r;
        end
    end

    logic pri_s, sec_s, oe_s, host_s;
    assign pri_s = sync2_r[1];
    assign sec_s = sync2_r[0];
    assign host_s = sync2_r[2];
    assign oe_s = sync2_r[3];

    // ------------------------------------------------------------
    // strap capture after reset release
    // ------------------------------------------------------------
    // the first two cycles after release still hold the flush of the
    // synchronisers, so capture waits for them to fill
    logic [1:0] settle_r;
    logic captured_r;
    io_type_t output_type_r;
    edge_rate_t edge_rate_r;
    io_type_t input_type_r;
    prescale_t prescale_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            settle_r <= 2'h0;
        end else if (settle_r != 2'h3) begin
            settle_r <= settle_r + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            captured_r <= 1'b0;
            output_type_r <= RST_OUTPUT_TYPE;
            edge_rate_r <= RST_EDGE_RATE;
            input_type_r <= RST_INPUT_TYPE;
            prescale_r <= RST_PRESCALE;
        end else if (!captured_r && settle_r == 2'h3) begin
            captured_r <= 1'b1;
            unique case (decode_strap(sync2_r[13], sync2_r[12]))
                STRAP_LOW: output_type_r <= IO_LVDS;
                STRAP_HIGH: output_type_r <= IO_HCSL;
                default: output_type_r <= IO_LVCMOS;
            endcase
            unique case (decode_strap(sync2_r[11], sync2_r[10]))
                STRAP_LOW: edge_rate_r <= EDGE_SLOW;
                STRAP_HIGH: edge_rate_r <= EDGE_MEDIUM;
                default: edge_rate_r <= EDGE_FAST;
            endcase
            unique case (decode_strap(sync2_r[9], sync2_r[8]))
                STRAP_LOW: input_type_r <= IO_LVDS;
                STRAP_HIGH: input_type_r <= IO_HCSL;
                default: input_type_r <= IO_LVCMOS;
            endcase
            unique case (decode_strap(sync2_r[7], sync2_r[6]))
                STRAP_LOW: prescale_r <= DIV_2;
                STRAP_HIGH: prescale_r <= DIV_4;
                default: prescale_r <= DIV_1;
            endcase
        end
    end

    // host path may pick any ratio, straps never reach divide by 8
    prescale_t prescale_eff;
    assign prescale_eff = host_s ? prescale_t'(host_prescale) : prescale_r;

    // ------------------------------------------------------------
    // continuous pins
    // ------------------------------------------------------------
    sel_mode_t sel_mode_r;
    logic oe_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_mode_r <= SEL_AUTO;
            oe_r <= 1'b0;
        end else begin
            oe_r <= oe_s;
            unique case (decode_strap(sync2_r[5], sync2_r[4]))
                STRAP_LOW: sel_mode_r <= SEL_MANUAL_PRI;
                STRAP_HIGH: sel_mode_r <= SEL_MANUAL_SEC;
                default: sel_mode_r <= SEL_AUTO;
            endcase
        end
    end

    // ------------------------------------------------------------
    // edge detection and secondary prescaler
    // ------------------------------------------------------------
    logic pri_d_r, sec_d_r;
    logic pri_rise, pri_fall, sec_rise;
    logic [PRESCALE_CNT_W-1:0] pre_cnt_r;
    logic div_clk_r;
    logic div_d_r;
    logic divided;
    logic div_rise;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pri_d_r <= 1'b0;
            sec_d_r <= 1'b0;
            div_d_r <= 1'b0;
        end else begin
            pri_d_r <= pri_s;
            sec_d_r <= sec_s;
            div_d_r <= divided;
        end
    end

    assign pri_rise = pri_s && !pri_d_r;
    assign pri_fall = !pri_s && pri_d_r;
    assign sec_rise = sec_s && !sec_d_r;

    // toggle every 2**(code-1) input rising edges
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_cnt_r <= '0;
            div_clk_r <= 1'b0;
        end else if (sec_rise) begin
            if (prescale_eff == DIV_1 || prescale_eff == DIV_2
                || (prescale_eff == DIV_4 && pre_cnt_r[0])
                || (prescale_eff == DIV_8 && pre_cnt_r == 2'h3)) begin
                pre_cnt_r <= '0;
                div_clk_r <= !div_clk_r;
            end else begin
                pre_cnt_r <= pre_cnt_r + 2'h1;
            end
        end
    end

    assign divided = (prescale_eff == DIV_1) ? sec_s : div_clk_r;
    assign div_rise = divided && !div_d_r;

    // ------------------------------------------------------------
    // loss monitors, each timed by the other clock
    // ------------------------------------------------------------
    logic pri_lost, sec_lost;

    clock_loss_monitor #(.TIMEOUT_EDGES(TIMEOUT_EDGES)) u_pri_mon (
        .clk(clk),
        .rst_b(rst_b),
        .mon_rise(pri_rise),
        .ref_rise(div_rise),
        .lost(pri_lost)
    );

    clock_loss_monitor #(.TIMEOUT_EDGES(TIMEOUT_EDGES)) u_sec_mon (
        .clk(clk),
        .rst_b(rst_b),
        .mon_rise(div_rise),
        .ref_rise(pri_rise),
        .lost(sec_lost)
    );

    // ------------------------------------------------------------
    // primary restore qualification
    // ------------------------------------------------------------
    // a returning primary must show four whole cycles before use
    logic [2:0] good_cnt_r;
    logic pri_good;
    localparam logic [2:0] RESTORE_LIM = 3'(RESTORE_CYCLES);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            good_cnt_r <= RESTORE_LIM;
        end else if (pri_lost) begin
            good_cnt_r <= 3'h0;
        end else if (pri_rise && good_cnt_r != RESTORE_LIM) begin
            good_cnt_r <= good_cnt_r + 3'h1;
        end
    end

    // count starts at the edge that clears loss; that edge opens cycle one
    assign pri_good = (good_cnt_r == RESTORE_LIM) && !pri_lost;

    // ------------------------------------------------------------
    // smart selector
    // ------------------------------------------------------------
    logic want_sec;
    mux_state_t mux_state_r;
    logic mux_out_r;

    assign want_sec = (sel_mode_r == SEL_MANUAL_SEC)
        || (sel_mode_r == SEL_AUTO && !pri_good);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mux_state_r <= MUX_PRI;
        end else begin
            unique case (mux_state_r)
                MUX_PRI: begin
                    if (want_sec) begin
                        mux_state_r <= MUX_TO_SEC;
                    end
                end
                MUX_TO_SEC: begin
                    if (div_rise) begin
                        mux_state_r <= MUX_SEC;
                    end
                end
                MUX_SEC: begin
                    // go with secondary high, primary low: no extra edge, no short pulse
                    if (!want_sec && divided && !pri_s) begin
                        mux_state_r <= MUX_TO_PRI;
                    end
                end
                MUX_TO_PRI: begin
                    if (pri_fall) begin
                        mux_state_r <= MUX_PRI;
                    end
                end
            endcase
        end
    end

    // output level per state; return to primary waits for a phase with secondary high, primary low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mux_out_r <= RST_MUX_OUT;
        end else begin
            unique case (mux_state_r)
                MUX_PRI: mux_out_r <= want_sec ? 1'b0 : pri_s;
                MUX_TO_SEC: mux_out_r <= div_rise ? divided : 1'b0;
                MUX_SEC: mux_out_r <= divided;
                MUX_TO_PRI: mux_out_r <= pri_fall ? 1'b0 : 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign output_type = output_type_r;
    assign edge_rate = edge_rate_r;
    assign input_type = input_type_r;
    assign secondary_prescaler = prescale_eff;
    assign outputs_enabled = oe_r;
    assign outputs_hiz = !oe_r;
    // unselected buffer powers down only in manual modes
    assign primary_buf_on = (sel_mode_r != SEL_MANUAL_SEC);
    assign secondary_buf_on = (sel_mode_r != SEL_MANUAL_PRI);
    assign mux_clk = mux_out_r;
    assign on_secondary = (mux_state_r == MUX_SEC);
    assign primary_lost = pri_lost;
    assign secondary_lost = sec_lost;

endmodule

// [bench/strap_clock_select_sva.sv]
// checker for the strap decoder and smart input selector
// assumes a bind onto strap_clock_select; sees its ports only
`timescale 1ns/1ps
module strap_clock_select_sva import strap_clock_pkg::*; #(
    parameter int TIMEOUT_EDGES = LOS_TIMEOUT_EDGES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pins
    input wire logic input_select_pin_up,
    input wire logic input_select_pin_dn,
    input wire logic output_enable_pin,
    input wire logic host_mode,
    // observed outputs
    input wire io_type_t output_type,
    input wire edge_rate_t edge_rate,
    input wire io_type_t input_type,
    input wire prescale_t secondary_prescaler,
    input wire logic outputs_enabled,
    input wire logic outputs_hiz,
    input wire logic primary_buf_on,
    input wire logic secondary_buf_on,
    input wire logic mux_clk,
    input wire logic on_secondary,
    input wire logic primary_lost
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [2:0] since_r;
    logic auto_w;
    // select pin left open means automatic mode
    assign auto_w = input_select_pin_up && !input_select_pin_dn;
    // cycles since reset release; saturates so straps are long captured
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            since_r <= 3'h0;
        end else if (since_r != 3'h7) begin
            since_r <= since_r + 3'h1;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_oe_on;
        output_enable_pin [*4] |-> outputs_enabled && !outputs_hiz;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("outputs not enabled");
    property p_oe_off;
        !output_enable_pin [*4] |-> !outputs_enabled && outputs_hiz;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("outputs not in hiz");
    property p_sel_sec;
        (input_select_pin_up && input_select_pin_dn) [*4] |-> secondary_buf_on && !primary_buf_on;
    endproperty
    a_sel_sec: assert property (p_sel_sec) else $error("wrong buffers for high select");
    property p_sel_auto;
        auto_w [*4] |-> primary_buf_on && secondary_buf_on;
    endproperty
    a_sel_auto: assert property (p_sel_auto) else $error("wrong buffers for auto");
    property p_held;
        since_r == 3'h7 |-> $stable(output_type) && $stable(edge_rate) && $stable(input_type);
    endproperty
    a_held: assert property (p_held) else $error("strap setting moved");
    property p_no8;
        !host_mode && !$past(host_mode) && !$past(host_mode, 2) |-> secondary_prescaler != DIV_8;
    endproperty
    a_no8: assert property (p_no8) else $error("divide by 8 without host");
    property p_lost_low;
        (auto_w && primary_lost && !on_secondary) [*4] |-> !mux_clk;
    endproperty
    a_lost_low: assert property (p_lost_low) else $error("output not low in switch");
    property p_switch;
        $rose(primary_lost) && auto_w |-> ##[1:30] on_secondary;
    endproperty
    a_switch: assert property (p_switch) else $error("no switch to secondary");
    property p_restore;
        $fell(primary_lost) && auto_w |-> ##30 on_secondary ##[1:80] !on_secondary;
    endproperty
    a_restore: assert property (p_restore) else $error("bad return timing");
    property p_no_glitch;
        auto_w && $rose(mux_clk) |-> mux_clk [*3];
    endproperty
    a_no_glitch: assert property (p_no_glitch) else $error("short high pulse");
    property p_back_high;
        $fell(on_secondary) && auto_w |-> ##[0:1] mux_clk;
    endproperty
    a_back_high: assert property (p_back_high) else $error("output not held high");
    c_loss: cover property ($rose(primary_lost) && auto_w);
    c_back: cover property ($fell(on_secondary) && auto_w);
    c_oe: cover property ($rose(outputs_enabled));
endmodule

// [bench/board_straps_clocks.sv]
// board model: three-level strap drivers and two reference clocks
// assumes the bench changes levels and run enables after a clk edge
`timescale 1ns/1ps
module board_straps_clocks import strap_clock_pkg::*; #(
    parameter int PRI_HALF_NS = 50,
    parameter int SEC_HALF_NS = 53
) (
    // five strap levels, two bits each
    input wire logic [9:0] strap_lvls,
    input wire logic pri_run,
    input wire logic sec_run,
    // sensed levels
    output logic [4:0] sense_up,
    output logic [4:0] sense_dn,
    // reference clocks
    output logic pri_clk,
    output logic sec_clk
);
    // open floats: pull-up reads high, pull-down reads low
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            sense_up[i] = strap_lvls[2*i +: 2] != STRAP_LOW;
            sense_dn[i] = strap_lvls[2*i +: 2] == STRAP_HIGH;
        end
    end
    // near periods keep the two sources within 20 percent at /1
    initial pri_clk = 1'b0;
    initial sec_clk = 1'b0;
    // a stopped source stands still, as a dead oscillator would
    always begin
        #(PRI_HALF_NS);
        if (pri_run) pri_clk = ~pri_clk;
    end
    always begin
        #(SEC_HALF_NS);
        if (sec_run) sec_clk = ~sec_clk;
    end
endmodule

// [bench/tb_strap_clock_select.sv]
// self-checking bench for the strap decoder and smart input selector
// assumes the board model and the bound checker
`timescale 1ns/1ps
module tb_strap_clock_select
    import strap_clock_pkg::*;
;
    logic clk, rst_b, pri_run, sec_run, pri_clk, sec_clk, oe_pin, host_mode;
    logic [9:0] strap_lvls;
    logic [4:0] s_up, s_dn;
    logic [1:0] host_prescale, lv;
    logic [7:0] saved;
    io_type_t output_type, input_type;
    edge_rate_t edge_rate;
    prescale_t secondary_prescaler;
    logic outputs_enabled, outputs_hiz, primary_buf_on, secondary_buf_on;
    logic mux_clk, on_secondary, primary_lost, secondary_lost;
    int err_count, n_compared, cycles, seed, i, k, n;
    // ------------------------------------------------------------
    // models and design
    // ------------------------------------------------------------
    board_straps_clocks i_board (.strap_lvls(strap_lvls), .pri_run(pri_run),
        .sec_run(sec_run), .sense_up(s_up), .sense_dn(s_dn), .pri_clk(pri_clk),
        .sec_clk(sec_clk));
    strap_clock_select #(.TIMEOUT_EDGES(4)) i_dut (.clk(clk), .rst_b(rst_b),
        .output_type_strap_up(s_up[0]), .output_type_strap_dn(s_dn[0]),
        .edge_rate_strap_up(s_up[1]), .edge_rate_strap_dn(s_dn[1]),
        .input_type_strap_up(s_up[2]), .input_type_strap_dn(s_dn[2]),
        .prescale_strap_up(s_up[3]), .prescale_strap_dn(s_dn[3]),
        .input_select_pin_up(s_up[4]), .input_select_pin_dn(s_dn[4]),
        .output_enable_pin(oe_pin), .host_mode(host_mode), .host_prescale(host_prescale),
        .primary_clock_input(pri_clk), .secondary_clock_input(sec_clk),
        .output_type(output_type), .edge_rate(edge_rate), .input_type(input_type),
        .secondary_prescaler(secondary_prescaler), .outputs_enabled(outputs_enabled),
        .outputs_hiz(outputs_hiz), .primary_buf_on(primary_buf_on),
        .secondary_buf_on(secondary_buf_on), .mux_clk(mux_clk), .on_secondary(on_secondary),
        .primary_lost(primary_lost), .secondary_lost(secondary_lost));
    // clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end
    // ------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic do_reset();
        rst_b = 1'b0;
        step(4);
        rst_b = 1'b1;
        step(6);
    endtask
    // bounded wait on the selector; returns cycles spent
    task automatic wait_sec(input logic want, output int c);
        c = 0;
        while (on_secondary !== want && c < 300) begin
            step(1);
            c++;
        end
    endtask
    // rising edges of the selector output over 100 cycles
    task automatic count_mux(output int c);
        logic last;
        c = 0;
        last = mux_clk;
        repeat (100) begin
            step(1);
            if (mux_clk && !last) c++;
            last = mux_clk;
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic io_type_t exp_io(input logic [1:0] l);
        return l == STRAP_LOW ? IO_LVDS : (l == STRAP_HIGH ? IO_HCSL : IO_LVCMOS);
    endfunction
    function automatic edge_rate_t exp_edge(input logic [1:0] l);
        return l == STRAP_LOW ? EDGE_SLOW : (l == STRAP_HIGH ? EDGE_MEDIUM : EDGE_FAST);
    endfunction
    function automatic prescale_t exp_div(input logic [1:0] l);
        return l == STRAP_LOW ? DIV_2 : (l == STRAP_HIGH ? DIV_4 : DIV_1);
    endfunction
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        pri_run = 1'b1;
        sec_run = 1'b1;
        oe_pin = 1'b0;
        host_mode = 1'b0;
        host_prescale = 2'h0;
        strap_lvls = {5{2'h2}};
        seed = 32'h5eec6022;
        // every level on every strap, then random mixes
        for (i = 0; i < 6; i++) begin
            for (k = 0; k < 5; k++) begin
                lv = (i < 3) ? i[1:0] : 2'($unsigned($random(seed)) % 3);
                strap_lvls[2*k +: 2] = lv;
            end
            do_reset();
            check("output_type", output_type, exp_io(strap_lvls[1:0]));
            check("edge_rate", edge_rate, exp_edge(strap_lvls[3:2]));
            check("input_type", input_type, exp_io(strap_lvls[5:4]));
            check("prescaler", secondary_prescaler, exp_div(strap_lvls[7:6]));
            check("pri_buf", primary_buf_on, strap_lvls[9:8] != STRAP_HIGH);
            check("sec_buf", secondary_buf_on, strap_lvls[9:8] != STRAP_LOW);
            saved = {output_type, edge_rate, input_type, secondary_prescaler};
            strap_lvls[7:0] = 8'($random(seed));
            step(8);
            check("held", {output_type, edge_rate, input_type, secondary_prescaler}, saved);
        end
        $display("strap decode done");
        // output enable toggled back to back, then at random
        for (i = 0; i < 8; i++) begin
            oe_pin = (i < 2) ? i[0] : 1'($random(seed));
            step(4);
            check("oe", outputs_enabled, oe_pin);
            check("hiz", outputs_hiz, !oe_pin);
        end
        // host path reaches every ratio, straps never give /8
        host_mode = 1'b1;
        for (i = 0; i < 4; i++) begin
            host_prescale = i[1:0];
            step(3);
            check("host_div", secondary_prescaler, i[7:0]);
        end
        host_prescale = 2'h0;
        step(1);
        host_mode = 1'b0;
        step(3);
        check("strap_div", secondary_prescaler, saved[1:0]);
        $display("enable and prescaler done");
        // manual selection both ways, undivided secondary
        strap_lvls = {5{2'h2}};
        do_reset();
        strap_lvls[9:8] = STRAP_HIGH;
        wait_sec(1'b1, n);
        check("manual_sec", on_secondary, 1'b1);
        strap_lvls[9:8] = STRAP_LOW;
        wait_sec(1'b0, n);
        check("manual_pri", on_secondary, 1'b0);
        count_mux(n);
        check("mux_follows", n >= 8 && n <= 11, 1'b1);
        // automatic: lose the primary, recover it, then lose the secondary
        strap_lvls[9:8] = STRAP_OPEN;
        step(8);
        pri_run = 1'b0;
        wait_sec(1'b1, n);
        check("pri_lost", primary_lost, 1'b1);
        check("auto_sec", on_secondary, 1'b1);
        count_mux(n);
        check("mux_on_sec", n >= 8 && n <= 11, 1'b1);
        pri_run = 1'b1;
        wait_sec(1'b0, n);
        check("restore_wait", n >= 40 && n < 300, 1'b1);
        check("pri_back", primary_lost, 1'b0);
        sec_run = 1'b0;
        step(80);
        check("sec_lost", secondary_lost, 1'b1);
        check("stay_pri", on_secondary, 1'b0);
        sec_run = 1'b1;
        $display("selector done");
        summarize();
    end
endmodule

bind strap_clock_select strap_clock_select_sva #(.TIMEOUT_EDGES(TIMEOUT_EDGES)) i_sva (
    .clk, .rst_b, .input_select_pin_up, .input_select_pin_dn, .output_enable_pin,
    .host_mode, .output_type, .edge_rate, .input_type, .secondary_prescaler,
    .outputs_enabled, .outputs_hiz, .primary_buf_on, .secondary_buf_on, .mux_clk,
    .on_secondary, .primary_lost);
